// *** doag_top.sv ***
// two operand address generators with post-modify and modulo wrap
`timescale 1ns/1ps
module doag_top #(
   parameter int AW = doag_pkg::ADDR_W
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire doag_pkg::doag_req_type DM_REQ,
   input wire doag_pkg::doag_req_type PM_REQ,
   input wire doag_pkg::doag_load_type DM_LOAD,
   input wire doag_pkg::doag_load_type PM_LOAD,
   output logic [doag_pkg::ADDR_W-1:0] DATA_MEMORY_ADDRESS_BUS,
   output logic [doag_pkg::ADDR_W-1:0] PROGRAM_MEMORY_ADDRESS_BUS,
   output logic DM_ADDR_VALID,
   output logic PM_ADDR_VALID
);
   import doag_pkg::*;

   // the buses are sized by the package width, so nothing else is served
   if (AW != ADDR_W) begin : gen_aw_check
      $error("AW must equal ADDR_W");
   end

   logic [ADDR_W-1:0] ptr_r [2][NPTR];
   logic [ADDR_W-1:0] ptr_nxt [2][NPTR];
   logic [ADDR_W-1:0] mod_r [2][NPTR];
   logic [ADDR_W-1:0] mod_nxt [2][NPTR];
   logic [ADDR_W-1:0] len_r [2][NPTR];
   logic [ADDR_W-1:0] len_nxt [2][NPTR];
   logic [ADDR_W-1:0] addr_r [2];
   logic [ADDR_W-1:0] addr_nxt [2];
   logic vld_r [2];
   logic vld_nxt [2];
   // base of each circular buffer, captured when a pointer is loaded
   logic [ADDR_W-1:0] base_r [2][NPTR];
   logic [ADDR_W-1:0] base_nxt [2][NPTR];
   doag_req_type req [2];
   doag_load_type ld [2];

   assign req[0] = DM_REQ;
   assign req[1] = PM_REQ;
   assign ld[0] = DM_LOAD;
   assign ld[1] = PM_LOAD;

   // modulo post-modify; modify magnitude must not exceed the length
   function automatic logic [ADDR_W-1:0] post_mod(
      input logic [ADDR_W-1:0] p,
      input logic [ADDR_W-1:0] m,
      input logic [ADDR_W-1:0] l,
      input logic [ADDR_W-1:0] b
   );
      logic [ADDR_W:0] sum;
      logic [ADDR_W:0] top;
      logic neg;
      sum = {1'b0, p} + {m[ADDR_W-1], m};
      top = {1'b0, b} + {1'b0, l};
      neg = m[ADDR_W-1];
      post_mod = sum[ADDR_W-1:0];
      if (l != LEN_ZERO) begin
         // full-width compare so a buffer ending at the top still wraps
         if (!neg && (sum >= top)) begin
            post_mod = ADDR_W'(sum - {1'b0, l});
         end else if (neg && (sum[ADDR_W-1:0] < b)) begin
            post_mod = ADDR_W'(sum[ADDR_W-1:0] + l);
         end
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_gen
         always_comb begin
            for (int i = 0; i < NPTR; i++) begin
               ptr_nxt[g][i] = ptr_r[g][i];
               mod_nxt[g][i] = mod_r[g][i];
               len_nxt[g][i] = len_r[g][i];
               base_nxt[g][i] = base_r[g][i];
            end
            addr_nxt[g] = addr_r[g];
            vld_nxt[g] = req[g].use_ptr;
            // access drives current pointer, then post-modifies it
            if (req[g].use_ptr) begin
               addr_nxt[g] = ptr_r[g][req[g].ptr_sel];
               ptr_nxt[g][req[g].ptr_sel] = post_mod(
                  ptr_r[g][req[g].ptr_sel], mod_r[g][req[g].mod_sel],
                  len_r[g][req[g].ptr_sel], base_r[g][req[g].ptr_sel]);
            end
            // a load wins over a post-modify of the same pointer
            if (ld[g].load_ptr) begin
               ptr_nxt[g][ld[g].sel] = ld[g].data;
               base_nxt[g][ld[g].sel] = ld[g].data;
            end
            if (ld[g].load_mod) mod_nxt[g][ld[g].sel] = ld[g].data;
            if (ld[g].load_len) len_nxt[g][ld[g].sel] = ld[g].data;
         end

         always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
               for (int i = 0; i < NPTR; i++) begin
                  ptr_r[g][i] <= PTR_RST;
                  mod_r[g][i] <= PTR_RST;
                  len_r[g][i] <= LEN_ZERO;
                  base_r[g][i] <= PTR_RST;
               end
               addr_r[g] <= PTR_RST;
               vld_r[g] <= 1'b0;
            end else begin
               for (int i = 0; i < NPTR; i++) begin
                  ptr_r[g][i] <= ptr_nxt[g][i];
                  mod_r[g][i] <= mod_nxt[g][i];
                  len_r[g][i] <= len_nxt[g][i];
                  base_r[g][i] <= base_nxt[g][i];
               end
               addr_r[g] <= addr_nxt[g];
               vld_r[g] <= vld_nxt[g];
            end
         end

         property p_addr_is_ptr;
            @(posedge MCLK) disable iff (!RST_B)
            req[g].use_ptr |=> addr_r[g] == $past(ptr_r[g][req[g].ptr_sel]);
         endproperty
         a_addr_is_ptr: assert property (p_addr_is_ptr)
            else $error("address is not the pointer before modify");

         property p_linear;
            @(posedge MCLK) disable iff (!RST_B)
            (req[g].use_ptr && !ld[g].load_ptr &&
             len_r[g][req[g].ptr_sel] == LEN_ZERO)
            |=> ptr_r[g][$past(req[g].ptr_sel)] ==
                ADDR_W'($past(ptr_r[g][req[g].ptr_sel]) +
                        $past(mod_r[g][req[g].mod_sel]));
         endproperty
         a_linear: assert property (p_linear)
            else $error("linear post-modify wrong");

         property p_in_buffer;
            @(posedge MCLK) disable iff (!RST_B)
            (req[g].use_ptr && !ld[g].load_ptr &&
             len_r[g][req[g].ptr_sel] != LEN_ZERO &&
             ptr_r[g][req[g].ptr_sel] >= base_r[g][req[g].ptr_sel] &&
             ptr_r[g][req[g].ptr_sel] - base_r[g][req[g].ptr_sel] <
             len_r[g][req[g].ptr_sel])
            |=> (ptr_r[g][$past(req[g].ptr_sel)] -
                 base_r[g][$past(req[g].ptr_sel)]) <
                len_r[g][$past(req[g].ptr_sel)];
         endproperty
         a_in_buffer: assert property (p_in_buffer)
            else $error("pointer left circular buffer");

         property p_valid;
            @(posedge MCLK) disable iff (!RST_B)
            req[g].use_ptr |=> vld_r[g];
         endproperty
         a_valid: assert property (p_valid)
            else $error("address valid missing");

         property p_load;
            @(posedge MCLK) disable iff (!RST_B)
            ld[g].load_ptr |=> ptr_r[g][$past(ld[g].sel)] ==
                               $past(ld[g].data);
         endproperty
         a_load: assert property (p_load)
            else $error("pointer load lost");

         property p_valid_drop;
            @(posedge MCLK) disable iff (!RST_B)
            !req[g].use_ptr |=> !vld_r[g];
         endproperty
         a_valid_drop: assert property (p_valid_drop)
            else $error("address valid held without access");

         // the bus keeps the last address between accesses
         property p_addr_hold;
            @(posedge MCLK) disable iff (!RST_B)
            !req[g].use_ptr |=> $stable(addr_r[g]);
         endproperty
         a_addr_hold: assert property (p_addr_hold)
            else $error("address changed without access");

         property p_mod_load;
            @(posedge MCLK) disable iff (!RST_B)
            ld[g].load_mod |=> mod_r[g][$past(ld[g].sel)] ==
                               $past(ld[g].data);
         endproperty
         a_mod_load: assert property (p_mod_load)
            else $error("modify load lost");

         property p_len_load;
            @(posedge MCLK) disable iff (!RST_B)
            ld[g].load_len |=> len_r[g][$past(ld[g].sel)] ==
                               $past(ld[g].data);
         endproperty
         a_len_load: assert property (p_len_load)
            else $error("length load lost");

         // a load and an access of one pointer: old value out, load kept
         sequence s_load_meets_access;
            req[g].use_ptr && ld[g].load_ptr &&
            ld[g].sel == req[g].ptr_sel;
         endsequence
         sequence s_old_out_load_kept;
            addr_r[g] == $past(ptr_r[g][ld[g].sel]) &&
            ptr_r[g][$past(ld[g].sel)] == $past(ld[g].data);
         endsequence
         property p_load_wins;
            @(posedge MCLK) disable iff (!RST_B)
            s_load_meets_access |=> s_old_out_load_kept;
         endproperty
         a_load_wins: assert property (p_load_wins)
            else $error("load did not win over post-modify");
      end
   endgenerate

   property p_dual;
      @(posedge MCLK) disable iff (!RST_B)
      (DM_REQ.use_ptr && PM_REQ.use_ptr) |=> (DM_ADDR_VALID && PM_ADDR_VALID);
   endproperty
   a_dual: assert property (p_dual)
      else $error("dual fetch not issued together");

   always_comb begin
      DATA_MEMORY_ADDRESS_BUS = addr_r[0];
      PROGRAM_MEMORY_ADDRESS_BUS = addr_r[1];
      DM_ADDR_VALID = vld_r[0];
      PM_ADDR_VALID = vld_r[1];
   end
endmodule

// *** doag_pkg.sv ***
// package for the dual operand address generator
package doag_pkg;
   localparam int ADDR_W = 14;
   localparam int NPTR = 4;
   localparam int SEL_W = 2;
   localparam logic [ADDR_W-1:0] PTR_RST = 14'h0000;
   localparam logic [ADDR_W-1:0] LEN_ZERO = 14'h0000;

   // one generator request from decode for a single cycle
   typedef struct packed {
      logic use_ptr;
      logic [1:0] ptr_sel;
      logic [1:0] mod_sel;
   } doag_req_type;

   // register load port from the sequencer side
   typedef struct packed {
      logic load_ptr;
      logic load_mod;
      logic load_len;
      logic [1:0] sel;
      logic [13:0] data;
   } doag_load_type;
endpackage

// *** tb_dual_operand_address_generator.sv ***
// self-checking bench for the dual operand address generator
`timescale 1ns/1ps
module tb_dual_operand_address_generator;
   import doag_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   doag_req_type dm_req = '0;
   doag_req_type pm_req = '0;
   doag_load_type dm_load = '0;
   doag_load_type pm_load = '0;
   logic [ADDR_W-1:0] dm_addr;
   logic [ADDR_W-1:0] pm_addr;
   logic dm_vld;
   logic pm_vld;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   always #5 mclk = ~mclk;
   doag_top i_doag_top (.MCLK(mclk), .RST_B(rst_b), .DM_REQ(dm_req),
      .PM_REQ(pm_req), .DM_LOAD(dm_load), .PM_LOAD(pm_load),
      .DATA_MEMORY_ADDRESS_BUS(dm_addr), .PROGRAM_MEMORY_ADDRESS_BUS(pm_addr),
      .DM_ADDR_VALID(dm_vld), .PM_ADDR_VALID(pm_vld));
   task automatic chk_addr(input logic [13:0] e, input logic [13:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_flag(input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // kind 0 pointer, 1 modify, 2 length
   task automatic ld(input bit pm, input int k, input int s, input int d);
      doag_load_type l;
      l = '0;
      l.load_ptr = (k == 0);
      l.load_mod = (k == 1);
      l.load_len = (k == 2);
      l.sel = 2'(s);
      l.data = 14'(d);
      @(posedge mclk);
      if (pm) pm_load <= l; else dm_load <= l;
      @(posedge mclk);
      if (pm) pm_load <= '0; else dm_load <= '0;
   endtask
   // valid must pulse for one cycle only, so it is checked twice
   task automatic acc(input doag_req_type d, input doag_req_type p,
                      input int ed, input int ep);
      @(posedge mclk);
      dm_req <= d;
      pm_req <= p;
      @(posedge mclk);
      dm_req <= '0;
      pm_req <= '0;
      @(negedge mclk);
      chk_flag(d.use_ptr, dm_vld);
      chk_flag(p.use_ptr, pm_vld);
      if (d.use_ptr) chk_addr(14'(ed), dm_addr);
      if (p.use_ptr) chk_addr(14'(ep), pm_addr);
      @(negedge mclk);
      chk_flag(1'b0, dm_vld | pm_vld);
      if (d.use_ptr) chk_addr(14'(ed), dm_addr);
      if (p.use_ptr) chk_addr(14'(ep), pm_addr);
   endtask
   task automatic t_circ;
      ld(0, 0, 0, 10);
      ld(0, 1, 0, 3);
      ld(0, 2, 0, 4);
      acc('{1'b1, 2'h0, 2'h0}, '0, 10, 0);
      acc('{1'b1, 2'h0, 2'h0}, '0, 13, 0);
      acc('{1'b1, 2'h0, 2'h0}, '0, 12, 0);
      acc('{1'b1, 2'h0, 2'h0}, '0, 11, 0);
      acc('{1'b1, 2'h0, 2'h0}, '0, 10, 0);
      $display("circular test done");
   endtask
   // negative modify wraps up from below the base
   task automatic t_neg;
      ld(0, 0, 2, 'h20);
      ld(0, 1, 2, -3);
      ld(0, 2, 2, 5);
      acc('{1'b1, 2'h2, 2'h2}, '0, 'h20, 0);
      acc('{1'b1, 2'h2, 2'h2}, '0, 'h22, 0);
      acc('{1'b1, 2'h2, 2'h2}, '0, 'h24, 0);
      acc('{1'b1, 2'h2, 2'h2}, '0, 'h21, 0);
      acc('{1'b1, 2'h2, 2'h2}, '0, 'h23, 0);
      $display("negative wrap test done");
   endtask
   // zero length on the program side: plain linear, negative modifies too
   task automatic t_lin;
      for (int i = 0; i < 4; i++) begin
         ld(1, 0, i, 'h40 * i + 'h10);
         ld(1, 1, i, i - 2);
      end
      for (int i = 0; i < 4; i++) begin
         acc('0, '{1'b1, 2'(i), 2'(i)}, 0, 'h40 * i + 'h10);
      end
      for (int i = 0; i < 4; i++) begin
         acc('0, '{1'b1, 2'(i), 2'(i)}, 0, 'h40 * i + 'he + i);
      end
      $display("linear test done");
   endtask
   task automatic t_dual;
      ld(0, 0, 1, 'h200);
      ld(0, 1, 1, 'h10);
      acc('{1'b1, 2'h1, 2'h1}, '{1'b1, 2'h0, 2'h0}, 'h200, 'hc);
      acc('{1'b1, 2'h1, 2'h1}, '{1'b1, 2'h0, 2'h0}, 'h210, 'ha);
      $display("dual test done");
   endtask
   // back-to-back accesses, then a load meeting an access of its pointer
   task automatic t_b2b;
      ld(0, 0, 3, 'h100);
      @(posedge mclk);
      dm_req <= '{1'b1, 2'h3, 2'h1};
      @(posedge mclk);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) dm_req <= '0;
         @(negedge mclk);
         chk_flag(1'b1, dm_vld);
         chk_addr(14'('h100 + 'h10 * i), dm_addr);
         @(posedge mclk);
      end
      @(negedge mclk);
      chk_flag(1'b0, dm_vld);
      chk_addr(14'h0120, dm_addr);
      @(posedge mclk);
      dm_req <= '{1'b1, 2'h3, 2'h1};
      dm_load <= '{1'b1, 1'b0, 1'b0, 2'h3, 14'h0300};
      @(posedge mclk);
      dm_req <= '0;
      dm_load <= '0;
      @(negedge mclk);
      chk_addr(14'h0130, dm_addr);
      acc('{1'b1, 2'h3, 2'h1}, '0, 'h300, 0);
      $display("back-to-back test done");
   endtask
   // reset in mid-run clears pointers and the address buses
   task automatic t_rst;
      @(posedge mclk);
      rst_b <= 1'b0;
      @(negedge mclk);
      chk_addr(14'h0000, dm_addr);
      chk_addr(14'h0000, pm_addr);
      chk_flag(1'b0, dm_vld | pm_vld);
      @(posedge mclk);
      rst_b <= 1'b1;
      acc('{1'b1, 2'h3, 2'h1}, '{1'b1, 2'h0, 2'h0}, 0, 0);
      $display("reset test done");
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      t_circ();
      t_neg();
      t_lin();
      t_dual();
      t_b2b();
      t_rst();
      tally_and_finish();
   end
endmodule
